// ==== azd_status.sv ====
// zeroing sequencer, event priority, indicator and axi4-lite registers
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module azd_status #(
  parameter int TICK_CYC = azd_pkg::TICK_CYC,
  parameter int WARM_MS = azd_pkg::WARM_MS,
  parameter int AZ_MAX_MS = azd_pkg::AZ_MAX_MS,
  parameter int AZ_STEP_MS = azd_pkg::AZ_STEP_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire azd_pkg::azd_evt_type evt_in,
  input wire logic [11:0] sensor_count,
  input wire logic maint_button,
  output azd_pkg::azd_led_type led,
  output azd_pkg::azd_msg_type disp_msg,
  output logic [11:0] disp_sensor,
  output logic [11:0] diff_zero_count,
  output logic irq
);
  import azd_pkg::*;

  logic [19:0] tick_cnt_q, warm_ms_q, az_ms_q, step_ms_q;
  logic [15:0] blink_ms_q, blink_cnt_q, blink_ms_d;
  logic [7:0] lfsr_q;
  logic tick, warm_done, phase_q, rnd_q;
  logic btn_s1_q, btn_s2_q, btn_s3_q, btn_rise;
  azd_az_type az_q;
  logic az_done_q, az_err_q, fatal_q, az_start, step_now, in_win;
  logic [11:0] dzc_q, shown_q;
  logic [NEV-1:0] ev, ev_prev_q, low_mask;
  logic [3:0] win;
  logic [NIRQ-1:0] irq_st_q, irq_msk_q, irq_set;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, wr_go;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, wmask, wm, rdata_q, rd_mux;
  logic [1:0] bresp_q, rresp_q, rd_resp;
  azd_led_type led_d, led_q;
  azd_msg_type msg_d, msg_q;

  ////////////////////////////////////////////////////////////////////////
  // time base: one tick per ms keeps the long counters narrow
  assign tick = tick_cnt_q == 20'(TICK_CYC - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      tick_cnt_q <= 20'h00000;
    else
      tick_cnt_q <= tick_cnt_q + 20'h00001;
  end

  // warm-up timer from power-up reset
  assign warm_done = warm_ms_q == 20'(WARM_MS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      warm_ms_q <= 20'h00000;
    else if (tick && !warm_done)
      warm_ms_q <= warm_ms_q + 20'h00001;
  end

  // push button is a pin: two flops before anything looks at it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
    end
    else
    begin
      btn_s1_q <= maint_button;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
    end
  end

  assign btn_rise = btn_s2_q && !btn_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // zeroing sequencer
  assign az_start = (wr_go && aw_addr_q == OFS_CTRL && wm[CTRL_START])
                  || (btn_rise && warm_done);
  assign step_now = az_q == AZ_RUN && tick
                  && step_ms_q == 20'(AZ_STEP_MS - 1);
  assign in_win = sensor_count >= BAL_NOM - BAL_TOL
               && sensor_count <= BAL_NOM + BAL_TOL;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      az_q <= AZ_IDLE;
      az_ms_q <= 20'h00000;
      step_ms_q <= 20'h00000;
      dzc_q <= DZC_RST;
      shown_q <= 12'h000;
      az_done_q <= 1'b0;
      az_err_q <= 1'b0;
    end
    else
    begin
      case (az_q)
        AZ_IDLE:
        begin
          if (az_start)
          begin
            az_q <= AZ_RUN;
            az_ms_q <= 20'h00000;
            step_ms_q <= 20'h00000;
            az_done_q <= 1'b0;
            az_err_q <= 1'b0;
          end
          else if (wr_go && aw_addr_q == OFS_CTRL && wm[CTRL_CLEAR])
          begin
            az_done_q <= 1'b0;
            az_err_q <= 1'b0;
          end
        end
        default:
        begin
          if (tick)
          begin
            az_ms_q <= az_ms_q + 20'h00001;
            step_ms_q <= step_now ? 20'h00000 : step_ms_q + 20'h00001;
          end
          if (step_now)
          begin
            shown_q <= sensor_count;
            if (in_win)
            begin
              az_q <= AZ_IDLE;
              az_done_q <= 1'b1;
            end
            else if (az_ms_q >= 20'(AZ_MAX_MS - AZ_STEP_MS))
            begin
              az_q <= AZ_IDLE;
              az_err_q <= 1'b1;
            end
            else if (sensor_count > BAL_NOM)
              dzc_q <= dzc_q - 12'h001;
            else
              dzc_q <= dzc_q + 12'h001;
          end
        end
      endcase
    end
  end

  // fatal stays latched until reset or a maintenance clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fatal_q <= 1'b0;
    else if (evt_in.fatal)
      fatal_q <= 1'b1;
    else if (wr_go && aw_addr_q == OFS_CTRL && wm[CTRL_CLEAR])
      fatal_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // event vector, bit index is the priority level
  always_comb
  begin
    ev[0] = az_q == AZ_RUN;
    ev[1] = fatal_q || evt_in.fatal || az_err_q;
    ev[2] = evt_in.cpu_hot;
    ev[3] = !warm_done && !ev[1] && !ev[2];
    ev[4] = evt_in.sens_cold;
    ev[5] = evt_in.sens_hot;
    ev[6] = evt_in.total_hit;
    ev[7] = evt_in.flow_low;
    ev[8] = evt_in.flow_high;
    ev[9] = ev[8:0] == 9'h000;
  end

  // scan from the least important so the lowest level wins
  always_comb
  begin
    win = EV_NORMAL;
    for (int i = NEV - 1; i >= 0; i--)
      if (ev[i])
        win = 4'(i);
  end

  ////////////////////////////////////////////////////////////////////////
  // blink phase and pseudo-random flicker
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blink_cnt_q <= 16'h0000;
      phase_q <= 1'b0;
      rnd_q <= 1'b0;
      lfsr_q <= LFSR_RST;
    end
    else if (tick)
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      if (blink_cnt_q >= blink_ms_q)
      begin
        blink_cnt_q <= 16'h0000;
        phase_q <= !phase_q;
        // toggling on only some edges breaks the period up
        if (lfsr_q[0])
          rnd_q <= !rnd_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 16'h0001;
    end
  end

  // indicator colours and message for the winning level
  always_comb
  begin
    led_d = '0;
    msg_d = MSG_ALARM;
    case (win)
      4'h0: begin led_d.red = rnd_q; msg_d = MSG_AZ_ON; end
      4'h1:
      begin
        led_d.red = 1'b1;
        msg_d = az_err_q ? MSG_AZ_ERR : MSG_FATAL;
      end
      4'h2: begin led_d.red = phase_q; led_d.amber_colour = !phase_q; end
      4'h3: begin led_d.amber_colour = 1'b1; msg_d = MSG_WARMUP; end
      4'h4: led_d.amber_colour = phase_q;
      4'h5: led_d.red = phase_q;
      4'h6: begin led_d.green = phase_q; led_d.amber_colour = !phase_q; end
      4'h7: led_d.green = phase_q;
      4'h8: begin led_d.green = phase_q; led_d.red = !phase_q; end
      default:
      begin
        led_d.green = 1'b1;
        msg_d = az_done_q ? MSG_AZ_DONE : MSG_NORMAL;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_q <= '0;
      msg_q <= MSG_NORMAL;
    end
    else
    begin
      led_q <= led_d;
      msg_q <= msg_d;
    end
  end

  assign led = led_q;
  assign disp_msg = msg_q;
  assign disp_sensor = shown_q;
  assign diff_zero_count = dzc_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over a same-cycle clear
  assign irq_set[IRQ_DONE] = step_now && in_win;
  assign irq_set[IRQ_FAIL] = step_now && !in_win
    && az_ms_q >= 20'(AZ_MAX_MS - AZ_STEP_MS);
  assign irq_set[IRQ_EVT] = |(ev[8:1] & ~ev_prev_q[8:1]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_st_q <= '0;
      irq_msk_q <= '0;
      ev_prev_q <= '0;
    end
    else
    begin
      ev_prev_q <= ev;
      if (wr_go && aw_addr_q == OFS_IRQ_ST)
        irq_st_q <= (irq_st_q & ~wm[NIRQ-1:0]) | irq_set;
      else
        irq_st_q <= irq_st_q | irq_set;
      if (wr_go && aw_addr_q == OFS_IRQ_MSK)
        irq_msk_q <= wm[NIRQ-1:0];
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data caught in either order
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wm = w_data_q;
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  assign blink_ms_d = w_data_q[15:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      bresp_q <= RESP_OKAY;
      blink_ms_q <= BLINK_RST;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_q)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_hold_q)
      begin
        w_hold_q <= 1'b1;
        // unstrobed lanes write zero, so they never start, clear or w1c; mask bytes take zero, blink bytes too unless the whole period is zero
        w_data_q <= s_axi_wdata & wmask;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (aw_addr_q <= OFS_IRQ_MSK) ? RESP_OKAY : RESP_DECERR;
        if (aw_addr_q == OFS_BLINK && blink_ms_d != 16'h0000)
          blink_ms_q <= blink_ms_d;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read decode
  always_comb
  begin
    rd_resp = RESP_OKAY;
    if (s_axi_araddr[7:2] == OFS_CTRL[7:2])
      rd_mux = {31'h00000000, az_q == AZ_RUN};
    else if (s_axi_araddr[7:2] == OFS_STAT[7:2])
      rd_mux = {16'h0000, az_err_q, az_done_q, win, ev};
    else if (s_axi_araddr[7:2] == OFS_ZERO[7:2])
      rd_mux = {4'h0, shown_q, 4'h0, dzc_q};
    else if (s_axi_araddr[7:2] == OFS_BLINK[7:2])
      rd_mux = {16'h0000, blink_ms_q};
    else if (s_axi_araddr[7:2] == OFS_IRQ_ST[7:2])
      rd_mux = {29'h00000000, irq_st_q};
    else if (s_axi_araddr[7:2] == OFS_IRQ_MSK[7:2])
      rd_mux = {29'h00000000, irq_msk_q};
    else
    begin
      rd_mux = 32'h00000000;
      rd_resp = RESP_DECERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_resp;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  always_comb
    for (int i = 0; i < NEV; i++)
      low_mask[i] = 4'(i) < win;

  property p_win_lowest;
    @(posedge aclk) disable iff (!aresetn)
    ev[win] && (ev & low_mask) == '0;
  endproperty
  a_win_lowest: assert property (p_win_lowest)
    else $error("winner is not the lowest active level");

  property p_az_top;
    @(posedge aclk) disable iff (!aresetn)
    az_q == AZ_RUN |=> led_q.green == 1'b0 && msg_q == MSG_AZ_ON;
  endproperty
  a_az_top: assert property (p_az_top)
    else $error("zeroing not shown as top level");

  property p_btn_warm;
    @(posedge aclk) disable iff (!aresetn)
    btn_rise && !warm_done && az_q == AZ_IDLE
      && !(wr_go && aw_addr_q == OFS_CTRL) |=> az_q == AZ_IDLE;
  endproperty
  a_btn_warm: assert property (p_btn_warm)
    else $error("button started zeroing during warm-up");

  property p_success;
    @(posedge aclk) disable iff (!aresetn)
    step_now && in_win |=> az_q == AZ_IDLE && az_done_q && !az_err_q;
  endproperty
  a_success: assert property (p_success)
    else $error("settled reading did not end zeroing");

  property p_fail_red;
    @(posedge aclk) disable iff (!aresetn)
    az_err_q && win == EV_FATAL |=> led_q == 3'b100 && msg_q == MSG_AZ_ERR;
  endproperty
  a_fail_red: assert property (p_fail_red)
    else $error("zeroing failure not steady red");

  property p_fatal_hold;
    @(posedge aclk) disable iff (!aresetn)
    fatal_q && !(wr_go && aw_addr_q == OFS_CTRL) |=> fatal_q;
  endproperty
  a_fatal_hold: assert property (p_fatal_hold)
    else $error("fatal dropped without clear");

  property p_normal;
    @(posedge aclk) disable iff (!aresetn)
    ev[8:0] == 9'h000 |=> led_q == 3'b001;
  endproperty
  a_normal: assert property (p_normal)
    else $error("idle state not steady green");

  property p_warmup;
    @(posedge aclk) disable iff (!aresetn)
    !warm_done && ev[2:0] == 3'b000 |-> win == 4'h3;
  endproperty
  a_warmup: assert property (p_warmup)
    else $error("warm-up not indicated");

  property p_az_bound;
    @(posedge aclk) disable iff (!aresetn)
    az_q == AZ_RUN |-> az_ms_q < 20'(AZ_MAX_MS);
  endproperty
  a_az_bound: assert property (p_az_bound)
    else $error("zeroing ran past its limit");

  property p_dzc_step;
    @(posedge aclk) disable iff (!aresetn)
    $changed(dzc_q) |-> $past(step_now);
  endproperty
  a_dzc_step: assert property (p_dzc_step)
    else $error("zero count moved off a step");

  c_success: cover property (@(posedge aclk) step_now && in_win);
  c_fail: cover property (@(posedge aclk) irq_set[IRQ_FAIL]);
  c_btn_block: cover property (@(posedge aclk) btn_rise && !warm_done);
  c_irq: cover property (@(posedge aclk) irq);
endmodule
`default_nettype wire

// ==== azd_pkg.sv ====
// shared constants and types for the zeroing and status priority block
package azd_pkg;
  // clock and time base
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // long times, counted in ms ticks
  localparam int WARM_MIN = 6;
  localparam int WARM_MS = WARM_MIN * 60 * 1000;
  localparam int AZ_MAX_MIN = 2;
  localparam int AZ_MAX_MS = AZ_MAX_MIN * 60 * 1000;
  localparam int AZ_STEP_S = 4;
  localparam int AZ_STEP_MS = AZ_STEP_S * 1000;
  // sensor balance window
  localparam logic [11:0] BAL_NOM = 12'h078;
  localparam logic [11:0] BAL_TOL = 12'h00a;
  // reset values
  localparam logic [11:0] DZC_RST = 12'h800;
  localparam logic [15:0] BLINK_RST = 16'h00fa;
  localparam logic [7:0] LFSR_RST = 8'h5a;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ZERO = 8'h08;
  localparam logic [7:0] OFS_BLINK = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_EVT = 2;
  localparam int NIRQ = 3;
  // event levels, 0 most important
  localparam int NEV = 10;
  localparam logic [3:0] EV_AZ = 4'h0;
  localparam logic [3:0] EV_FATAL = 4'h1;
  localparam logic [3:0] EV_NORMAL = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic red;
    logic amber_colour;
    logic green;
  } azd_led_type;

  // external event sources, all on aclk
  typedef struct packed {
    logic fatal;
    logic cpu_hot;
    logic sens_cold;
    logic sens_hot;
    logic total_hit;
    logic flow_low;
    logic flow_high;
  } azd_evt_type;

  typedef enum logic [2:0] {
    MSG_NORMAL, MSG_AZ_ON, MSG_AZ_DONE, MSG_AZ_ERR, MSG_FATAL, MSG_WARMUP,
    MSG_ALARM
  } azd_msg_type;

  typedef enum logic {AZ_IDLE, AZ_RUN} azd_az_type;
endpackage

// ==== azd_sensor_model.sv ====
// sensor partner: the reading follows the zero adjust count
`timescale 1ns/1ps
`default_nettype none
module azd_sensor_model (
  input wire logic [11:0] diff_zero_count,
  input wire logic [11:0] offset,
  output logic [11:0] sensor_count
);
  // one count of adjust moves the reading by one count
  assign sensor_count = offset + diff_zero_count - 12'h800;
endmodule
`default_nettype wire

// ==== azd_status_test.sv ====
// self-checking bench for the zeroing and status priority block
`timescale 1ns/1ps
`default_nettype none
module azd_status_test;
  import azd_pkg::*;
  localparam int TC = 4;
  localparam int WM = 20;
  localparam int MX = 40;
  localparam int ST = 5;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, maint_button = 0, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  azd_evt_type evt_in = '0;
  azd_led_type led;
  azd_msg_type disp_msg;
  logic [11:0] sensor_count, disp_sensor, dzc, offset = 12'h078;
  int err_count = 0, comparisons = 0, seed = 32'hcddc7b10, lv, msk, n;
  // model count carries over from one zeroing run to the next
  int c = 12'h800, s;
  bit dn;
  azd_status #(.TICK_CYC(TC), .WARM_MS(WM), .AZ_MAX_MS(MX),
    .AZ_STEP_MS(ST)) u_azd_status (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .evt_in(evt_in), .sensor_count(sensor_count),
    .maint_button(maint_button), .led(led), .disp_msg(disp_msg),
    .disp_sensor(disp_sensor), .diff_zero_count(dzc), .irq(irq));
  azd_sensor_model u_azd_sensor_model (.diff_zero_count(dzc),
    .offset(offset), .sensor_count(sensor_count));
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    err_count++;
    $display("BAD %s expected answer seen none", nm);
    end_of_test();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bus master: ready is looked at mid-cycle, where it holds till the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ah)
        awvalid <= 0;
      if (wh)
        wvalid <= 0;
      if (bh)
      begin
        bready <= 0;
        return;
      end
    end
    hang("bvalid");
  endtask
  task automatic rdr(input logic [7:0] a);
    bit ah;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge aclk);
      ah = arvalid && arready;
      rd = rdata;
      rsp = rresp;
      if (rvalid)
      begin
        @(posedge aclk);
        rready <= 0;
        return;
      end
      @(posedge aclk);
      if (ah)
        arvalid <= 0;
    end
    hang("rvalid");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // indicator: over five half periods show exactly colours a and b
  task automatic pat(input logic [2:0] a, input logic [2:0] b);
    bit sa, sb, so;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge aclk);
      sa |= (led === a);
      sb |= (led === b);
      so |= (led !== a && led !== b);
    end
    chk("led_pattern", {sa, sb, so}, 3'b110);
  endtask
  task automatic wait_msg(input azd_msg_type m, input int lim);
    for (n = 0; n < lim && disp_msg !== m; n++)
      @(negedge aclk);
    if (n == lim)
      hang("disp_msg");
  endtask
  // event model: bit b of evt_in to level, lowest level wins
  function automatic int lvl_of(input int b);
    return (b == 6) ? 1 : (b == 5) ? 2 : 8 - b;
  endfunction
  // zeroing model, stepping the count toward the balance window
  task automatic zero_model(input int off);
    dn = 0;
    for (int k = 1; k < 40; k++)
    begin
      s = off + c - 12'h800;
      if (s >= 110 && s <= 130)
      begin
        dn = 1;
        return;
      end
      // elapsed time lags the step tick by one ms
      if (k * ST > MX - ST)
        return;
      c += (s > 120) ? -1 : 1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    // reset values and warm-up indication
    rdr(OFS_BLINK);
    chk("blink_reset", rd, 32'h0000_00fa);
    chk("rd_resp", rsp, RESP_OKAY);
    rdr(OFS_IRQ_MSK);
    chk("mask_reset", rd, 32'h0);
    rdr(OFS_ZERO);
    chk("zero_reset", rd[11:0], 12'h800);
    chk("warm_led", led, 3'b010);
    chk("warm_msg", disp_msg, MSG_WARMUP);
    // button during warm-up must not start zeroing
    @(posedge aclk) maint_button <= 1;
    repeat (4) @(posedge aclk);
    maint_button <= 0;
    repeat (6) @(posedge aclk);
    rdr(OFS_CTRL);
    chk("button_warm", rd[0], 1'b0);
    wait_msg(MSG_NORMAL, WM * TC * 2);
    pat(3'b001, 3'b001);
    $display("reset and warm-up done");
    // blink period: zero ignored, then shortest
    wr(OFS_BLINK, 32'h0);
    rdr(OFS_BLINK);
    chk("blink_zero", rd, 32'h0000_00fa);
    wr(OFS_BLINK, 32'h1);
    chk("wr_resp", rsp, RESP_OKAY);
    wr(8'h18, 32'h1);
    chk("unmapped_wr", rsp, RESP_DECERR);
    rdr(8'h18);
    chk("unmapped_rd", rd, 32'h0);
    chk("unmapped_resp", rsp, RESP_DECERR);
    // each alarm except fatal alone, its pattern and its status
    for (int b = 0; b < 6; b++)
    begin
      @(posedge aclk) evt_in <= azd_evt_type'(7'h1 << b);
      // the indicator follows one edge later
      @(posedge aclk);
      lv = lvl_of(b);
      case (lv)
        2: pat(3'b100, 3'b010);
        4: pat(3'b010, 3'b000);
        5: pat(3'b100, 3'b000);
        6: pat(3'b001, 3'b010);
        7: pat(3'b001, 3'b000);
        default: pat(3'b001, 3'b100);
      endcase
      rdr(OFS_STAT);
      chk("stat_one", rd[13:0], {4'(lv), 10'(1 << lv)});
    end
    // random mixes: all readable, most important wins
    for (int t = 0; t < 20; t++)
    begin
      @(posedge aclk) evt_in <= azd_evt_type'($random(seed) & 7'h3f);
      repeat (3) @(posedge aclk);
      lv = 9;
      msk = 0;
      for (int b = 0; b < 6; b++)
        if (evt_in[b])
        begin
          msk |= 1 << lvl_of(b);
          lv = (lvl_of(b) < lv) ? lvl_of(b) : lv;
        end
      if (msk == 0)
        msk = 1 << 9;
      rdr(OFS_STAT);
      chk("stat_mix", rd[13:0], {4'(lv), 10'(msk)});
    end
    @(posedge aclk) evt_in <= '0;
    $display("event priority done");
    // fatal pulse latches until cleared, raises the event interrupt
    wr(OFS_IRQ_ST, 32'h7);
    wr(OFS_IRQ_MSK, 32'h4);
    chk("irq_clear", irq, 1'b0);
    @(posedge aclk) evt_in <= 7'h40;
    @(posedge aclk) evt_in <= '0;
    pat(3'b100, 3'b100);
    chk("fatal_msg", disp_msg, MSG_FATAL);
    chk("irq_set", irq, 1'b1);
    rdr(OFS_STAT);
    chk("fatal_lvl", rd[13:10], EV_FATAL);
    wr(OFS_IRQ_MSK, 32'h0);
    chk("irq_mask", irq, 1'b0);
    wr(OFS_IRQ_ST, 32'h4);
    rdr(OFS_IRQ_ST);
    chk("irq_w1c", rd[2:0], 3'b000);
    wr(OFS_CTRL, 32'h2);
    pat(3'b001, 3'b001);
    $display("fatal and interrupt done");
    // successful zeroing from the host
    @(posedge aclk) offset <= 12'd135;
    wr(OFS_IRQ_MSK, 32'h3);
    wr(OFS_CTRL, 32'h1);
    rdr(OFS_CTRL);
    chk("az_run", rd[0], 1'b1);
    rdr(OFS_STAT);
    chk("az_lvl", rd[13:10], EV_AZ);
    chk("az_msg", disp_msg, MSG_AZ_ON);
    for (int i = 0; i < 40; i++)
    begin
      @(negedge aclk);
      chk("az_led", led[1:0], 2'b00);
    end
    zero_model(135);
    wait_msg(MSG_AZ_DONE, MX * TC + 40);
    pat(3'b001, 3'b001);
    rdr(OFS_ZERO);
    chk("az_count", rd[11:0], 12'(c));
    chk("az_sample", rd[27:16], 12'(s));
    chk("disp_sensor", disp_sensor, 12'(s));
    rdr(OFS_STAT);
    chk("az_done", {dn, rd[15:14]}, 3'b101);
    chk("irq_done", irq, 1'b1);
    $display("zeroing success done");
    // reading out of reach: failure
    offset <= 12'd400;
    wr(OFS_IRQ_ST, 32'h7);
    wr(OFS_CTRL, 32'h1);
    zero_model(400);
    wait_msg(MSG_AZ_ERR, MX * TC + 40);
    pat(3'b100, 3'b100);
    rdr(OFS_STAT);
    chk("az_err", {dn, rd[15:10]}, {3'b010, EV_FATAL});
    rdr(OFS_IRQ_ST);
    chk("irq_fail", rd[1], 1'b1);
    $display("zeroing failure done");
    // button after warm-up starts zeroing
    offset <= 12'd125;
    @(posedge aclk) maint_button <= 1;
    wait_msg(MSG_AZ_ON, 20);
    @(posedge aclk) maint_button <= 0;
    zero_model(125);
    wait_msg(MSG_AZ_DONE, MX * TC + 40);
    rdr(OFS_ZERO);
    chk("btn_count", rd[11:0], 12'(c));
    chk("btn_done", dn, 1'b1);
    $display("button zeroing done");
    end_of_test();
  end
endmodule
`default_nettype wire
